// *** airflow_pkg.sv ***
// constants, register map and types of the airflow alarm input logic
package airflow_pkg;
  localparam int          CLK_NS   = 5;
  localparam int          SEC_NS   = 1000000000;
  localparam logic [7:0]  OFS_CTRL = 8'h00;
  localparam logic [7:0]  OFS_INCFG = 8'h04;
  localparam logic [7:0]  OFS_START = 8'h08;
  localparam logic [7:0]  OFS_TEMP = 8'h0C;
  localparam logic [7:0]  OFS_SASH = 8'h10;
  localparam logic [7:0]  OFS_DELAY = 8'h14;
  localparam logic [7:0]  OFS_STAT = 8'h18;
  localparam logic [7:0]  OFS_RELAY = 8'h1C;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_DEC = 2'h3;
  // ctrl fields
  localparam int C_PB2 = 0;      // 2 bits
  localparam int C_PB3 = 2;      // 2 bits
  localparam int C_ENTER_EN = 4;
  localparam int C_REPEAT = 5;
  localparam int C_REDUCE = 6;
  localparam int C_EXT_RED = 7;
  localparam int C_EXT_TXT = 8;
  localparam int C_EMR_RED = 9;
  localparam int C_EMR_TXT = 10;
  localparam int C_RLY = 16;     // one relay enable per alarm
  localparam int INCFG_W = 6;    // per input: mode[5:4] function[3:0]
  localparam int NIN = 3;
  localparam int AW = 12;
  localparam int HI_LIM = 16;
  localparam int CNT_W = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // alarm indices
  localparam int A_PURGE = 0;
  localparam int A_MAX = 1;
  localparam int A_LOWT = 2;
  localparam int A_HIT = 3;
  localparam int A_SASH = 4;
  localparam int A_EXT = 5;
  localparam int A_EMER = 6;
  localparam int A_CS = 7;
  localparam int A_MAINS = 8;
  localparam int NAL = 9;
  typedef enum logic [1:0] {PB2_LIGHTS, PB2_UV, PB2_PUMP, PB2_SPARE} pb2_t;
  typedef enum logic [1:0] {PB3_SCRUB, PB3_PURGE, PB3_VAV3, PB3_VAV2} pb3_t;
  typedef enum logic [1:0] {M_ANALOG, M_OPEN, M_CLOSED, M_UNUSED} in_mode_t;
  typedef enum logic [3:0] {
    F_NONE, F_TEMP, F_SASHPOS, F_VOLUME, F_DAMPER, F_DISABLE, F_NIGHT, F_EXT,
    F_EMER, F_SASHHI, F_HILO, F_CLOSESASH, F_MAINS, F_PERSON, F_FANSTOP, F_MUTE
  } fn_t;
  typedef enum logic [1:0] {V_MIN, V_RUN, V_MAX} vav_t;
  typedef enum logic [3:0] {
    T_AIRFLOW, T_OFF, T_START, T_DISABLED, T_MAINS, T_EMER, T_CLOSE,
    T_SASHHI, T_LOWT, T_HIT, T_EXT, T_STANDBY, T_BLANK
  } text_t;
endpackage

// *** airflow_alarm_input_logic.sv ***
// function logic of the fume cupboard airflow controller with axi4-lite registers
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module airflow_alarm_input_logic
  import airflow_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_NS / CLK_NS
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite slave
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // pushbutton presses, one cycle each
  input  wire logic              pb1_press,
  input  wire logic              pb2_press,
  input  wire logic              pb3_press,
  input  wire logic              enter_press,
  // field inputs
  input  wire logic [NIN-1:0]    contact,
  input  wire logic [NIN*AW-1:0] ain,
  input  wire logic              sash_closed,
  // indications
  output text_t                  text,
  output logic                   red_led,
  output logic                   amber_led,
  output logic                   sounder,
  output logic                   mute_icon,
  output logic                   night_icon,
  output logic                   up_arrow,
  output logic                   down_arrow,
  // control outputs
  output vav_t                   vav_demand,
  output logic                   sp_high,
  output logic                   reduced_thresh,
  output logic                   low_air_mute,
  output logic                   airflow_alarm_en,
  output logic                   inhibit,
  output logic [1:0]             vol_in_sel,
  output logic [1:0]             damper_in_sel,
  // relays
  output logic                   rly_lights,
  output logic                   rly_uv,
  output logic                   rly_pump,
  output logic                   rly_scrub,
  output logic                   rly_hilo,
  output logic [NAL-1:0]         rly_alarm
);
  localparam logic [27:0] SEC_LAST = 28'(SEC_CYCLES - 1);

  typedef struct packed {
    logic              fan_on;
    logic [CNT_W-1:0]  start_cnt;
    logic [27:0]       sec_cnt;
    logic              blink;
    logic              pb2_rly;
    logic              pb3_rly;
    vav_t              vav_pos;
    logic [NAL-1:0]    muted;
    logic [CNT_W-1:0]  cs_cnt;
    logic [CNT_W-1:0]  rep_cnt;
    logic              fstop_prev;
    logic [31:0]       ctrl;
    logic [31:0]       incfg;
    logic [31:0]       start_time;
    logic [31:0]       temp_lim;
    logic [31:0]       sash_lim;
    logic [31:0]       delays;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        wa;
    logic [31:0]       wd;
    logic [3:0]        ws;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    // outputs held in flip-flops
    text_t             text;
    logic              red;
    logic              amber;
    logic              snd;
    logic              micon;
    vav_t              vav;
    logic [NAL-1:0]    rly;
  } st_t;

  st_t s_q, s_d;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[b*8 +: 8] = n[b*8 +: 8];
    end
    return r;
  endfunction

  // decoded input functions
  logic [15:0]     fn_act;
  logic [NIN-1:0]  temp_lo;
  logic [NIN-1:0]  temp_hi;
  logic [NIN-1:0]  sash_hi_a;
  logic            person_cfg;
  logic            tick;
  logic [NAL-1:0]  al;
  logic [NAL-1:0]  snd_req;
  logic            force_mute;
  logic            cs_sound;
  logic            red_solid;
  logic            red_flash;
  logic            wr_go;
  logic [31:0]     rd_val;
  logic            rd_ok;
  pb2_t            pb2_sel;
  pb3_t            pb3_sel;

  always_comb begin
    fn_t            f;
    in_mode_t       m;
    logic [AW-1:0]  v;
    f = F_NONE;
    m = M_UNUSED;
    v = '0;
    fn_act = '0;
    temp_lo = '0;
    temp_hi = '0;
    sash_hi_a = '0;
    person_cfg = 1'b0;
    vol_in_sel = 2'h0;
    damper_in_sel = 2'h0;
    for (int i = 0; i < NIN; i++) begin
      f = fn_t'(s_q.incfg[i*INCFG_W +: 4]);
      m = in_mode_t'(s_q.incfg[i*INCFG_W+4 +: 2]);
      v = ain[i*AW +: AW];
      if (f == F_PERSON) person_cfg = 1'b1;
      if (m == M_ANALOG) begin
        if (f == F_TEMP) begin
          temp_lo[i] = v < s_q.temp_lim[AW-1:0];
          temp_hi[i] = v > s_q.temp_lim[HI_LIM +: AW];
        end
        if (f == F_SASHPOS) sash_hi_a[i] = v > s_q.sash_lim[AW-1:0];
        // first input cannot carry duct volume or damper feedback
        if (i != 0 && f == F_VOLUME) vol_in_sel = 2'(i + 1);
        if (i != 0 && f == F_DAMPER) damper_in_sel = 2'(i + 1);
      end else if (m != M_UNUSED) begin
        fn_act[f] = fn_act[f] | (m == M_OPEN ? ~contact[i] : contact[i]);
      end
    end
  end

  assign pb2_sel = pb2_t'(s_q.ctrl[C_PB2 +: 2]);
  assign pb3_sel = pb3_t'(s_q.ctrl[C_PB3 +: 2]);
  assign tick = s_q.sec_cnt == SEC_LAST;
  // inhibit follows the start-up timer only; fan off and fan stop clear that timer
  assign inhibit = s_q.start_cnt != '0;
  assign cs_sound = fn_act[F_CLOSESASH] && s_q.cs_cnt == '0;

  always_comb begin
    al = '0;
    al[A_PURGE] = pb3_sel == PB3_PURGE && s_q.pb3_rly;
    al[A_MAX] = pb3_sel == PB3_VAV3 && s_q.vav_pos == V_MAX;
    al[A_LOWT] = |temp_lo;
    al[A_HIT] = |temp_hi;
    al[A_SASH] = |sash_hi_a || fn_act[F_SASHHI];
    al[A_EXT] = fn_act[F_EXT];
    al[A_EMER] = fn_act[F_EMER];
    // an operator at the front clears it as well as a closed sash
    al[A_CS] = fn_act[F_CLOSESASH] && !(sash_closed || fn_act[F_PERSON]);
    al[A_MAINS] = fn_act[F_MAINS];
    snd_req = al;
    snd_req[A_CS] = al[A_CS] && cs_sound;
    force_mute = fn_act[F_DISABLE] || fn_act[F_NIGHT] || fn_act[F_FANSTOP] ||
                 fn_act[F_MUTE] || !s_q.fan_on ||
                 (pb3_sel inside {PB3_VAV3, PB3_VAV2} && s_q.vav_pos == V_MIN);
    red_solid = !s_q.fan_on || fn_act[F_FANSTOP] || fn_act[F_MUTE] ||
                al[A_CS] || al[A_MAINS];
    red_flash = fn_act[F_DISABLE] || al[A_PURGE] || al[A_MAX] || al[A_LOWT] ||
                al[A_HIT] || (al[A_EXT] && s_q.ctrl[C_EXT_RED]) ||
                (al[A_EMER] && s_q.ctrl[C_EMR_RED]) ||
                (pb3_sel inside {PB3_VAV3, PB3_VAV2} && s_q.vav_pos == V_MIN);
  end

  always_comb begin
    s_d = s_q;
    // seconds base and a blink that toggles once a second for flashing leds
    s_d.sec_cnt = tick ? '0 : s_q.sec_cnt + 28'h000_0001;
    if (tick) s_d.blink = ~s_q.blink;
    // pushbutton one switching the fan on and the end of fan stop reload the start-up timer
    s_d.fstop_prev = fn_act[F_FANSTOP];
    if (pb1_press) begin
      s_d.fan_on = ~s_q.fan_on;
      s_d.start_cnt = s_q.fan_on ? '0 : s_q.start_time[CNT_W-1:0];
    end else if (s_q.fstop_prev && !fn_act[F_FANSTOP]) begin
      s_d.start_cnt = s_q.start_time[CNT_W-1:0];
    end else if (fn_act[F_FANSTOP]) begin
      s_d.start_cnt = '0;
    end else if (tick && inhibit) begin
      s_d.start_cnt = s_q.start_cnt - 16'h0001;
    end
    if (pb2_press) s_d.pb2_rly = ~s_q.pb2_rly;
    if (pb3_press) begin
      s_d.pb3_rly = ~s_q.pb3_rly;
      case (s_q.vav_pos)
        V_MIN: s_d.vav_pos = V_RUN;
        V_RUN: s_d.vav_pos = pb3_sel == PB3_VAV3 ? V_MAX : V_MIN;
        default: s_d.vav_pos = V_MIN;
      endcase
    end
    // close sash sounder delay, reloaded while the input is quiet
    if (!fn_act[F_CLOSESASH]) s_d.cs_cnt = s_q.delays[CNT_W-1:0];
    else if (tick && s_q.cs_cnt != '0) s_d.cs_cnt = s_q.cs_cnt - 16'h0001;
    // mute bits: enter sets, clearing alarm drops them
    for (int a = 0; a < NAL; a++) begin
      if (!al[a]) s_d.muted[a] = 1'b0;
      else if (enter_press && !fn_act[F_MUTE] && snd_req[a] &&
               ((a != A_CS && a != A_MAINS) || s_q.ctrl[C_ENTER_EN]))
        s_d.muted[a] = 1'b1;
    end
    // repeat timer re-arms a muted digital sash high alarm
    if (!(s_q.muted[A_SASH] && fn_act[F_SASHHI] && s_q.ctrl[C_REPEAT])) begin
      s_d.rep_cnt = s_q.delays[HI_LIM +: CNT_W];
    end else if (tick) begin
      if (s_q.rep_cnt <= 16'h0001) s_d.muted[A_SASH] = 1'b0;
      else s_d.rep_cnt = s_q.rep_cnt - 16'h0001;
    end
    // registered indications
    if (!s_q.fan_on || fn_act[F_FANSTOP]) s_d.text = T_OFF;
    else if (inhibit) s_d.text = T_START;
    else if (fn_act[F_DISABLE]) s_d.text = T_DISABLED;
    else if (al[A_MAINS]) s_d.text = T_MAINS;
    else if ((al[A_PURGE] || al[A_MAX] || (al[A_EMER] && s_q.ctrl[C_EMR_TXT])) && s_q.blink)
      s_d.text = T_EMER;
    else if (al[A_CS] && s_q.blink) s_d.text = T_CLOSE;
    else if (al[A_SASH] && s_q.blink) s_d.text = T_SASHHI;
    else if (al[A_LOWT] && s_q.blink) s_d.text = T_LOWT;
    else if (al[A_HIT] && s_q.blink) s_d.text = T_HIT;
    else if (al[A_EXT] && s_q.ctrl[C_EXT_TXT] && s_q.blink) s_d.text = T_EXT;
    else if (force_mute && !fn_act[F_MUTE] && s_q.vav_pos == V_MIN &&
             pb3_sel inside {PB3_VAV3, PB3_VAV2} && s_q.blink) s_d.text = T_STANDBY;
    else if (|al || force_mute) s_d.text = T_BLANK;
    else s_d.text = T_AIRFLOW;
    s_d.red = red_solid || (red_flash && s_q.blink);
    s_d.amber = al[A_SASH] && (!s_q.muted[A_SASH] || s_q.blink);
    s_d.snd = !inhibit && !force_mute && |(snd_req & ~s_q.muted);
    s_d.micon = fn_act[F_DISABLE] || fn_act[F_NIGHT] || fn_act[F_MUTE] ||
                |(s_q.muted & al);
    if (al[A_PURGE] || al[A_MAX] || al[A_EMER]) s_d.vav = V_MAX;
    else if (fn_act[F_NIGHT]) s_d.vav = V_MIN;
    else if (pb3_sel inside {PB3_VAV3, PB3_VAV2}) s_d.vav = s_q.vav_pos;
    else s_d.vav = V_RUN;
    s_d.rly = inhibit ? '0 : al & s_q.ctrl[C_RLY +: NAL];
    // axi4-lite write path: address and data in either order
    if (awvalid && awready) begin
      s_d.aw_got = 1'b1;
      s_d.wa = awaddr;
    end
    if (wvalid && wready) begin
      s_d.w_got = 1'b1;
      s_d.wd = wdata;
      s_d.ws = wstrb;
    end
    if (wr_go) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OK;
      case (s_q.wa)
        OFS_CTRL: s_d.ctrl = merge(s_q.ctrl, s_q.wd, s_q.ws);
        OFS_INCFG: s_d.incfg = merge(s_q.incfg, s_q.wd, s_q.ws);
        OFS_START: s_d.start_time = merge(s_q.start_time, s_q.wd, s_q.ws);
        OFS_TEMP: s_d.temp_lim = merge(s_q.temp_lim, s_q.wd, s_q.ws);
        OFS_SASH: s_d.sash_lim = merge(s_q.sash_lim, s_q.wd, s_q.ws);
        OFS_DELAY: s_d.delays = merge(s_q.delays, s_q.wd, s_q.ws);
        OFS_STAT, OFS_RELAY: s_d.bresp = RESP_OK;
        default: s_d.bresp = RESP_DEC;
      endcase
    end else if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_val;
      s_d.rresp = rd_ok ? RESP_OK : RESP_DEC;
    end else if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (!aresetn) begin
      s_d = '0;
      s_d.ctrl = CTRL_RST;
      s_d.vav_pos = V_RUN;
      s_d.vav = V_RUN;
      s_d.text = T_OFF;
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    case (araddr)
      OFS_CTRL: rd_val = s_q.ctrl;
      OFS_INCFG: rd_val = s_q.incfg;
      OFS_START: rd_val = s_q.start_time;
      OFS_TEMP: rd_val = s_q.temp_lim;
      OFS_SASH: rd_val = s_q.sash_lim;
      OFS_DELAY: rd_val = s_q.delays;
      OFS_STAT: rd_val = {s_q.start_cnt, 3'h0, al, s_q.fan_on, s_q.vav_pos, s_q.micon};
      OFS_RELAY: rd_val = {16'h0000, 2'h0, s_q.rly, rly_hilo, rly_scrub, rly_pump, rly_uv,
                           rly_lights};
      default: begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  assign wr_go = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign awready = !s_q.aw_got && !s_q.bvalid;
  assign wready = !s_q.w_got && !s_q.bvalid;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = !s_q.rvalid;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign text = s_q.text;
  assign red_led = s_q.red;
  assign amber_led = s_q.amber;
  assign sounder = s_q.snd;
  assign mute_icon = s_q.micon;
  assign night_icon = fn_act[F_NIGHT];
  assign up_arrow = fn_act[F_HILO];
  assign down_arrow = !fn_act[F_HILO];
  assign vav_demand = s_q.vav;
  assign sp_high = !person_cfg || fn_act[F_PERSON];
  assign reduced_thresh = !sp_high || (fn_act[F_NIGHT] && s_q.ctrl[C_REDUCE]);
  assign low_air_mute = fn_act[F_NIGHT] && !s_q.ctrl[C_REDUCE];
  assign airflow_alarm_en = !inhibit && !force_mute && s_q.vav == V_RUN;
  assign rly_lights = !inhibit && pb2_sel == PB2_LIGHTS && s_q.pb2_rly;
  assign rly_uv = !inhibit && pb2_sel == PB2_UV && s_q.pb2_rly;
  assign rly_pump = !inhibit && pb2_sel == PB2_PUMP && s_q.pb2_rly;
  assign rly_scrub = !inhibit && pb3_sel == PB3_SCRUB && s_q.pb3_rly;
  assign rly_hilo = !inhibit && fn_act[F_HILO] && s_q.ctrl[C_RLY + NAL];
  assign rly_alarm = s_q.rly;

  property p_inhibit_quiet;
    @(posedge aclk) disable iff (!aresetn) inhibit |=> !sounder && rly_alarm == '0;
  endproperty
  a_inhibit_quiet: assert property (p_inhibit_quiet) else $error("output during start-up");
  property p_purge_max;
    @(posedge aclk) disable iff (!aresetn) al[A_PURGE] |=> vav_demand == V_MAX;
  endproperty
  a_purge_max: assert property (p_purge_max) else $error("purge not at vav max");
  property p_emer_max;
    @(posedge aclk) disable iff (!aresetn) fn_act[F_EMER] |=> vav_demand == V_MAX;
  endproperty
  a_emer_max: assert property (p_emer_max) else $error("emergency not at vav max");
  property p_night_min;
    @(posedge aclk) disable iff (!aresetn)
      fn_act[F_NIGHT] && !fn_act[F_EMER] && !al[A_PURGE] && !al[A_MAX] |=> vav_demand == V_MIN;
  endproperty
  a_night_min: assert property (p_night_min) else $error("night set-back not at min");
  property p_disable_mutes;
    @(posedge aclk) disable iff (!aresetn) fn_act[F_DISABLE] |=> !sounder && mute_icon;
  endproperty
  a_disable_mutes: assert property (p_disable_mutes) else $error("disable not muted");
  property p_mute_input;
    @(posedge aclk) disable iff (!aresetn) fn_act[F_MUTE] |=> red_led && !sounder;
  endproperty
  a_mute_input: assert property (p_mute_input) else $error("mute input ignored");
  property p_mute_clears;
    @(posedge aclk) disable iff (!aresetn)
      s_q.muted[A_EXT] && !al[A_EXT] |=> !s_q.muted[A_EXT];
  endproperty
  a_mute_clears: assert property (p_mute_clears) else $error("mute outlived alarm");
  property p_no_vol_in1;
    @(posedge aclk) disable iff (!aresetn) vol_in_sel != 2'h1 && damper_in_sel != 2'h1;
  endproperty
  a_no_vol_in1: assert property (p_no_vol_in1) else $error("volume on input one");
  property p_max_three_pos;
    @(posedge aclk) disable iff (!aresetn)
      pb3_press && s_q.vav_pos == V_RUN && pb3_sel == PB3_VAV2 |=> s_q.vav_pos == V_MIN;
  endproperty
  a_max_three_pos: assert property (p_max_three_pos) else $error("max in two-pos");
  property p_enter_icon;
    @(posedge aclk) disable iff (!aresetn) s_q.muted[A_EXT] && al[A_EXT] |=> mute_icon;
  endproperty
  a_enter_icon: assert property (p_enter_icon) else $error("mute icon missing");
  c_purge: cover property (@(posedge aclk) disable iff (!aresetn) al[A_PURGE] ##1 sounder);
  c_enter_mute: cover property (@(posedge aclk) disable iff (!aresetn)
    sounder ##1 enter_press ##2 !sounder && mute_icon);
  c_startup: cover property (@(posedge aclk) disable iff (!aresetn) inhibit ##1 !inhibit);
  c_wr: cover property (@(posedge aclk) disable iff (!aresetn) bvalid && bready);
endmodule
`default_nettype wire

// *** field_model.sv ***
// field side model: contacts and analogue codes seen by the controller
`timescale 1ns/1ps
`default_nettype none
module field_model (
  input  wire logic        aclk,
  input  wire logic [2:0]  want,
  output logic      [2:0]  contact,
  output logic      [35:0] ain,
  output logic             sash_closed
);
  // no bounce modelled, contacts follow the demand at once
  always_comb begin
    contact     = want;
    ain         = 36'h800_800_800;
    sash_closed = 1'b0;
  end
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench of the airflow alarm input logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import airflow_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  btn = 4'h0;
  logic [2:0]  want = 3'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, sounder, mute_icon, inhibit;
  logic        rly_lights, rly_uv, rly_pump, rly_scrub, alarm_en, sash_closed;
  logic        red_led, amber_led, night_icon, up_arrow, down_arrow, rly_hilo;
  logic        sp_high, reduced_thresh, low_air_mute;
  logic [1:0]  bresp, rresp, vol_in_sel, dmp_sel;
  logic [31:0] rdata;
  logic [2:0]  contact;
  logic [35:0] ain;
  logic [NAL-1:0] rly_alarm;
  text_t       text;
  vav_t        vav_demand;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  always #2.5 aclk = ~aclk;
  field_model fm (.aclk(aclk), .want(want), .contact(contact), .ain(ain),
                  .sash_closed(sash_closed));
  airflow_alarm_input_logic #(.SEC_CYCLES(8)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pb1_press(btn[0]),
    .pb2_press(btn[1]), .pb3_press(btn[2]), .enter_press(btn[3]), .contact(contact),
    .ain(ain), .sash_closed(sash_closed), .text(text), .red_led(red_led),
    .amber_led(amber_led), .sounder(sounder), .mute_icon(mute_icon),
    .night_icon(night_icon), .up_arrow(up_arrow), .down_arrow(down_arrow),
    .vav_demand(vav_demand), .sp_high(sp_high), .reduced_thresh(reduced_thresh),
    .low_air_mute(low_air_mute), .airflow_alarm_en(alarm_en), .inhibit(inhibit),
    .vol_in_sel(vol_in_sel), .damper_in_sel(dmp_sel), .rly_lights(rly_lights),
    .rly_uv(rly_uv), .rly_pump(rly_pump), .rly_scrub(rly_scrub), .rly_hilo(rly_hilo),
    .rly_alarm(rly_alarm));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // hang guard: whole run is well under two thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ga, gw;
    ga = 1'b0;
    gw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge aclk);
      if (!ga && awready) begin
        ga = 1'b1;
        awvalid <= 1'b0;
      end
      if (!gw && wready) begin
        gw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    chk("bresp", bresp, er);
    bready <= 1'b0;
    // registered outputs follow a new setting one edge after the write lands
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    chk("rdata", rdata, e);
    chk("rresp", rresp, er);
    rready <= 1'b0;
  endtask
  // one-cycle press, then room for the registered indications to settle
  task automatic tap(input int i);
    @(posedge aclk);
    btn[i] <= 1'b1;
    @(posedge aclk);
    btn <= 4'h0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic fld(input logic [2:0] w);
    @(posedge aclk);
    want <= w;
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("text", text, T_OFF);
    chk("vav", vav_demand, V_RUN);
    rd(OFS_CTRL, 32'h0, RESP_OK);
    wr(8'hFC, 32'h1, RESP_DEC);
    rd(8'hFC, 32'h0, RESP_DEC);
    wr(OFS_START, 32'h2, RESP_OK);
    tap(0);
    chk("inhibit", inhibit, 1'b1);
    repeat (24) @(posedge aclk);
    chk("inhibit", inhibit, 1'b0);
    for (int f = 0; f < 3; f++) begin
      wr(OFS_CTRL, f, RESP_OK);
      tap(1);
      chk("pb2 relay", {rly_pump, rly_uv, rly_lights}, 1 << f);
      tap(1);
      chk("pb2 relay", {rly_pump, rly_uv, rly_lights}, 0);
    end
    wr(OFS_CTRL, 32'h0, RESP_OK);
    tap(2);
    chk("scrub", rly_scrub, 1'b1);
    tap(2);
    chk("scrub", rly_scrub, 1'b0);
    wr(OFS_CTRL, 32'h8, RESP_OK);
    tap(2);
    chk("vav", vav_demand, V_MAX);
    tap(2);
    chk("vav", vav_demand, V_MIN);
    chk("sounder", sounder, 1'b0);
    tap(2);
    chk("vav", vav_demand, V_RUN);
    chk("alarm enable", alarm_en, 1'b1);
    // emergency on input one, closed contact, relay enabled
    wr(OFS_CTRL, 32'h0040_0000, RESP_OK);
    wr(OFS_INCFG, 32'h28, RESP_OK);
    fld(3'h1);
    chk("vav", vav_demand, V_MAX);
    chk("sounder", sounder, 1'b1);
    chk("emer relay", rly_alarm[A_EMER], 1'b1);
    tap(3);
    chk("sounder", sounder, 1'b0);
    chk("mute icon", mute_icon, 1'b1);
    fld(3'h0);
    fld(3'h1);
    chk("sounder", sounder, 1'b1);
    wr(OFS_INCFG, 32'h18, RESP_OK);
    chk("vav", vav_demand, V_RUN);
    fld(3'h0);
    chk("vav", vav_demand, V_MAX);
    wr(OFS_INCFG, 32'h0002_F028, RESP_OK);
    fld(3'h5);
    chk("sounder", sounder, 1'b0);
    chk("mute icon", mute_icon, 1'b1);
    fld(3'h0);
    wr(OFS_INCFG, 32'hC3, RESP_OK);
    chk("vol sel", vol_in_sel, 2'h2);
    wr(OFS_INCFG, 32'h03, RESP_OK);
    chk("vol sel", vol_in_sel, 2'h0);
    wr(OFS_INCFG, 32'h4004, RESP_OK);
    chk("damper sel", dmp_sel, 2'h3);
    // analogue codes idle at 800h: low temperature limit above, sash limit below
    wr(OFS_TEMP, 32'h0FFF_0900, RESP_OK);
    wr(OFS_INCFG, 32'h01, RESP_OK);
    chk("sounder", sounder, 1'b1);
    wr(OFS_SASH, 32'h700, RESP_OK);
    wr(OFS_INCFG, 32'h02, RESP_OK);
    chk("amber", amber_led, 1'b1);
    tap(3);
    chk("sounder", sounder, 1'b0);
    // digital sash high, repeat after two seconds
    wr(OFS_CTRL, 32'h20, RESP_OK);
    wr(OFS_DELAY, 32'h0002_0000, RESP_OK);
    wr(OFS_INCFG, 32'h29, RESP_OK);
    fld(3'h1);
    tap(3);
    chk("sounder", sounder, 1'b0);
    repeat (24) @(posedge aclk);
    chk("sounder", sounder, 1'b1);
    fld(3'h0);
    wr(OFS_INCFG, 32'h26, RESP_OK);
    fld(3'h1);
    chk("night icon", night_icon, 1'b1);
    chk("vav", vav_demand, V_MIN);
    chk("low air mute", low_air_mute, 1'b1);
    chk("mute icon", mute_icon, 1'b1);
    fld(3'h0);
    wr(OFS_CTRL, 32'h0200_0000, RESP_OK);
    wr(OFS_INCFG, 32'h2A, RESP_OK);
    fld(3'h1);
    chk("arrows", {up_arrow, down_arrow, rly_hilo}, 3'h5);
    fld(3'h0);
    chk("arrows", {up_arrow, down_arrow, rly_hilo}, 3'h2);
    // close sash on input one, personnel sensor on input two
    wr(OFS_INCFG, 32'hB6B, RESP_OK);
    fld(3'h1);
    chk("red", red_led, 1'b1);
    chk("set point", {sp_high, reduced_thresh}, 2'h1);
    fld(3'h3);
    chk("red", red_led, 1'b0);
    chk("set point", {sp_high, reduced_thresh}, 2'h2);
    fld(3'h0);
    wr(OFS_INCFG, 32'h25, RESP_OK);
    fld(3'h1);
    chk("text", text, T_DISABLED);
    chk("mute icon", mute_icon, 1'b1);
    fld(3'h0);
    wr(OFS_INCFG, 32'h2C, RESP_OK);
    fld(3'h1);
    chk("text", text, T_MAINS);
    chk("red", red_led, 1'b1);
    tap(3);
    chk("sounder", sounder, 1'b1);
    fld(3'h0);
    wr(OFS_INCFG, 32'h2E, RESP_OK);
    fld(3'h1);
    chk("text", text, T_OFF);
    chk("red", red_led, 1'b1);
    chk("sounder", sounder, 1'b0);
    fld(3'h0);
    chk("text", text, T_START);
    chk("inhibit", inhibit, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
